// File: verilog/rtc_core.sv
// Real-time clock core: control registers, time and calendar counters
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Halt bit set freezes time, calendar, alarm and timer; clearing it resumes.
// - While halted, clock output runs only at 32.768 kHz; other rates stop low.
// - While halted, the serial bus timeout is disabled.
// - After halt clears, seconds advance once after half a second.
// - Timer repeat select: one repeats timer events, zero gives single shot.
// - Alarm event sets the alarm flag; it stays until the host changes it.
// - Timer event sets the timer flag; it stays until the host changes it.
// - Alarm enable lets a set alarm flag pull the interrupt pin low.
// - Timer enable lets a set timer flag pull the interrupt pin low.
// - Seconds, minutes and hours are held as packed BCD.
// - Seconds and minutes count 00 to 59, wrap, and carry onward.
// - Hours count 00 to 23, wrap, and carry into the day.
// - Low-voltage flag sets at power-up and whenever supply drops below threshold.
// - A write to the seconds register clears the low-voltage flag unless the supply is below threshold.
// - Day, month and year are packed BCD, updated automatically 2001 to 2099.
// - Day wraps after 31, 30 or 28 depending on the month.
// - Years that are multiples of four let February reach 29.
// - Month counts January to December, wraps, and carries into the year.
// - Year counts 00 to 99 and wraps.
module rtc_core
	import rtc_pkg::*;
(
	// Clock, reset and freeze
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_en,
	// Register port
	input wire rtc_bus_req_t bus_req,
	output logic [7:0] reg_rdata,
	// Crystal, supply monitor and clock-output enable pins (asynchronous)
	input wire logic xtal_clk,
	input wire logic low_voltage_threshold,
	input wire logic clock_output_enable,
	// Settings and events from neighbouring alarm, timer and clock-output logic
	input wire logic [1:0] clock_output_select,
	input wire logic alarm_event,
	input wire logic timer_event,
	// State shown to neighbouring logic
	output logic counters_halted,
	output logic bus_timeout_enable,
	output logic timer_repeat_select,
	output logic one_hz_tick,
	// Open-drain pins: output level and active-low output enable
	output logic clock_output_pin_o,
	output logic clock_output_pin_oe_n,
	output logic irq_n_o,
	output logic irq_n_oe_n
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Increment packed BCD, wrapping to lo once max is reached
	function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] max, input logic [7:0] lo);
		logic [7:0] r;
		r = v;
		if (v == max) begin
			r = lo;
		end else if (v[3:0] == 4'h9) begin
			r = {4'(v[7:4] + 4'h1), 4'h0};
		end else begin
			r = {v[7:4], 4'(v[3:0] + 4'h1)};
		end
		return r;
	endfunction

	// Last day of the month, leap rule applied to the two-digit year
	function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
		logic leap;
		logic [7:0] r;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		r = DAYS_LONG;
		if (m == MONTH_FEB) begin
			r = leap ? DAYS_FEB_LEAP : DAYS_FEB;
		end else if (m == MONTH_APR || m == MONTH_JUN || m == MONTH_SEP || m == MONTH_NOV) begin
			r = DAYS_SHORT;
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic xtal_s1_reg, xtal_s2_reg, xtal_s3_reg;
	logic lv_s1_reg, lv_s2_reg;
	logic coe_s1_reg, coe_s2_reg;
	logic xtal_rise;

	// Two flops per pin; the third crystal flop only serves edge finding
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			xtal_s1_reg <= 1'b0;
			xtal_s2_reg <= 1'b0;
			xtal_s3_reg <= 1'b0;
			lv_s1_reg <= 1'b0;
			lv_s2_reg <= 1'b0;
			coe_s1_reg <= 1'b0;
			coe_s2_reg <= 1'b0;
		end else if (clk_en) begin
			xtal_s1_reg <= xtal_clk;
			xtal_s2_reg <= xtal_s1_reg;
			xtal_s3_reg <= xtal_s2_reg;
			lv_s1_reg <= low_voltage_threshold;
			lv_s2_reg <= lv_s1_reg;
			coe_s1_reg <= clock_output_enable;
			coe_s2_reg <= coe_s1_reg;
		end
	end

	assign xtal_rise = xtal_s2_reg & ~xtal_s3_reg;

	// ----------------------------------------------------------------
	// Register write decode
	// ----------------------------------------------------------------
	logic wr_ctl1, wr_ctl2, wr_sec, wr_min, wr_hour, wr_day, wr_mon, wr_year;

	assign wr_ctl1 = bus_req.wr && bus_req.addr == OFF_CONTROL_ONE;
	assign wr_ctl2 = bus_req.wr && bus_req.addr == OFF_CONTROL_TWO;
	assign wr_sec = bus_req.wr && bus_req.addr == OFF_SECONDS;
	assign wr_min = bus_req.wr && bus_req.addr == OFF_MINUTES;
	assign wr_hour = bus_req.wr && bus_req.addr == OFF_HOURS;
	assign wr_day = bus_req.wr && bus_req.addr == OFF_DAY_OF_MONTH;
	assign wr_mon = bus_req.wr && bus_req.addr == OFF_MONTH;
	assign wr_year = bus_req.wr && bus_req.addr == OFF_YEAR;

	// ----------------------------------------------------------------
	// First control register: halt and test bits
	// ----------------------------------------------------------------
	logic halt_reg;
	logic test_hi_reg, test_lo_reg;

	// Test bits are stored only so software reads back what it wrote
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			halt_reg <= 1'b0;
			test_hi_reg <= 1'b0;
			test_lo_reg <= 1'b0;
		end else if (clk_en && wr_ctl1) begin
			halt_reg <= bus_req.wdata[BIT_HALT];
			test_hi_reg <= bus_req.wdata[BIT_TEST_HI];
			test_lo_reg <= bus_req.wdata[BIT_TEST_LO];
		end
	end

	assign counters_halted = halt_reg;
	assign bus_timeout_enable = ~halt_reg;

	// ----------------------------------------------------------------
	// One-second prescaler on crystal edges
	// ----------------------------------------------------------------
	logic [PRESC_W-1:0] presc_reg;
	logic sec_tick;

	// Resume preset keeps the clock within half a second of a restart from halt
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			presc_reg <= PRESC_RST;
		end else if (clk_en) begin
			if (wr_ctl1 && halt_reg && !bus_req.wdata[BIT_HALT]) begin
				presc_reg <= PRESC_RESUME;
			end else if (xtal_rise && !halt_reg) begin
				presc_reg <= PRESC_W'(presc_reg + 1'b1);
			end
		end
	end

	assign sec_tick = xtal_rise && !halt_reg && (&presc_reg);
	assign one_hz_tick = sec_tick;

	// ----------------------------------------------------------------
	// Time and calendar counters (packed BCD)
	// ----------------------------------------------------------------
	logic [7:0] sec_reg, min_reg, hour_reg, day_reg, mon_reg, year_reg;
	logic c_min, c_hour, c_day, c_mon, c_year;

	// Carry chain; host writes in the same cycle override counting
	assign c_min = sec_tick && sec_reg == MAX_MIN_SEC;
	assign c_hour = c_min && min_reg == MAX_MIN_SEC;
	assign c_day = c_hour && hour_reg == MAX_HOUR;
	assign c_mon = c_day && day_reg == month_len(mon_reg, year_reg);
	assign c_year = c_mon && mon_reg == MAX_MONTH;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sec_reg <= RST_ZERO;
			min_reg <= RST_ZERO;
			hour_reg <= RST_ZERO;
			day_reg <= RST_ONE;
			mon_reg <= RST_ONE;
			year_reg <= RST_ONE;
		end else if (clk_en) begin
			if (wr_sec) begin
				sec_reg <= bus_req.wdata & MASK_SECONDS;
			end else if (sec_tick) begin
				sec_reg <= bcd_step(sec_reg, MAX_MIN_SEC, RST_ZERO);
			end
			if (wr_min) begin
				min_reg <= bus_req.wdata & MASK_MINUTES;
			end else if (c_min) begin
				min_reg <= bcd_step(min_reg, MAX_MIN_SEC, RST_ZERO);
			end
			if (wr_hour) begin
				hour_reg <= bus_req.wdata & MASK_HOURS;
			end else if (c_hour) begin
				hour_reg <= bcd_step(hour_reg, MAX_HOUR, RST_ZERO);
			end
			if (wr_day) begin
				day_reg <= bus_req.wdata & MASK_DAY;
			end else if (c_day) begin
				day_reg <= bcd_step(day_reg, month_len(mon_reg, year_reg), RST_ONE);
			end
			if (wr_mon) begin
				mon_reg <= bus_req.wdata & MASK_MONTH;
			end else if (c_mon) begin
				mon_reg <= bcd_step(mon_reg, MAX_MONTH, RST_ONE);
			end
			if (wr_year) begin
				year_reg <= bus_req.wdata & MASK_YEAR;
			end else if (c_year) begin
				year_reg <= bcd_step(year_reg, MAX_YEAR, RST_ZERO);
			end
		end
	end

	// ----------------------------------------------------------------
	// Low-voltage flag
	// ----------------------------------------------------------------
	logic low_voltage_flag_reg;

	// Reset stands for power-on from zero volts; a drop wins over a clearing write
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			low_voltage_flag_reg <= 1'b1;
		end else if (clk_en) begin
			if (lv_s2_reg) begin
				low_voltage_flag_reg <= 1'b1;
			end else if (wr_sec) begin
				low_voltage_flag_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Second control register: flags, enables, timer mode
	// ----------------------------------------------------------------
	rtc_ctl_two_t ctl2_reg;
	logic alarm_set, timer_set;

	// Events are ignored while halted since alarm and timer are frozen
	assign alarm_set = alarm_event && !halt_reg;
	assign timer_set = timer_event && !halt_reg;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctl2_reg <= RST_CTL_TWO;
		end else if (clk_en) begin
			if (wr_ctl2) begin
				ctl2_reg.timer_repeat_select <= bus_req.wdata[4];
				ctl2_reg.alarm_irq_enable <= bus_req.wdata[1];
				ctl2_reg.timer_irq_enable <= bus_req.wdata[0];
				ctl2_reg.alarm_flag <= bus_req.wdata[3] | alarm_set;
				ctl2_reg.timer_flag <= bus_req.wdata[2] | timer_set;
			end else begin
				ctl2_reg.alarm_flag <= ctl2_reg.alarm_flag | alarm_set;
				ctl2_reg.timer_flag <= ctl2_reg.timer_flag | timer_set;
			end
		end
	end

	assign timer_repeat_select = ctl2_reg.timer_repeat_select;

	// ----------------------------------------------------------------
	// Interrupt pin (open drain, low when active)
	// ----------------------------------------------------------------
	logic irq_active;

	assign irq_active = (ctl2_reg.alarm_flag && ctl2_reg.alarm_irq_enable)
		|| (ctl2_reg.timer_flag && ctl2_reg.timer_irq_enable);
	assign irq_n_o = 1'b0;
	assign irq_n_oe_n = ~irq_active;

	// ----------------------------------------------------------------
	// Clock output pin (open drain)
	// ----------------------------------------------------------------
	rtc_freq_t freq_sel;
	logic clk_level;

	assign freq_sel = rtc_freq_t'(clock_output_select);

	// Divided rates hold low while halted; the crystal rate keeps running
	always_comb begin
		case (freq_sel)
			RTC_FREQ_32K: clk_level = xtal_s2_reg;
			RTC_FREQ_1024: clk_level = !halt_reg && presc_reg[TAP_1024HZ];
			RTC_FREQ_32: clk_level = !halt_reg && presc_reg[TAP_32HZ];
			RTC_FREQ_1: clk_level = !halt_reg && presc_reg[TAP_1HZ];
			default: clk_level = 1'b0;
		endcase
	end

	assign clock_output_pin_o = 1'b0;
	assign clock_output_pin_oe_n = !(coe_s2_reg && !clk_level);

	// ----------------------------------------------------------------
	// Read port: data in the cycle after the strobe only
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reg_rdata <= RST_ZERO;
		end else if (clk_en) begin
			reg_rdata <= RST_ZERO;
			if (bus_req.rd) begin
				case (bus_req.addr)
					OFF_CONTROL_ONE: reg_rdata <= {test_hi_reg, 1'b0, halt_reg, 1'b0, test_lo_reg, 3'b000};
					OFF_CONTROL_TWO: reg_rdata <= {3'b000, ctl2_reg};
					OFF_SECONDS: reg_rdata <= {low_voltage_flag_reg, sec_reg[6:0]};
					OFF_MINUTES: reg_rdata <= min_reg;
					OFF_HOURS: reg_rdata <= hour_reg;
					OFF_DAY_OF_MONTH: reg_rdata <= day_reg;
					OFF_MONTH: reg_rdata <= mon_reg;
					OFF_YEAR: reg_rdata <= year_reg;
					default: reg_rdata <= RST_ZERO;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_halt_freeze;
		@(posedge ref_clk) disable iff (srst)
		halt_reg && !wr_sec |=> $stable(sec_reg);
	endproperty
	a_halt_freeze: assert property (p_halt_freeze) else $error("seconds moved while halted");

	property p_clock_output_pin_halt;
		@(posedge ref_clk) disable iff (srst)
		halt_reg && coe_s2_reg && freq_sel != RTC_FREQ_32K |-> !clock_output_pin_oe_n;
	endproperty
	a_clock_output_pin_halt: assert property (p_clock_output_pin_halt) else $error("divided clock output not held low");

	property p_timeout_off;
		@(posedge ref_clk) disable iff (srst)
		bus_timeout_enable != halt_reg;
	endproperty
	a_timeout_off: assert property (p_timeout_off) else $error("bus timeout not tied to halt");

	property p_resume_half;
		@(posedge ref_clk) disable iff (srst)
		clk_en && wr_ctl1 && halt_reg && !bus_req.wdata[BIT_HALT] |=> presc_reg == PRESC_RESUME && !halt_reg;
	endproperty
	a_resume_half: assert property (p_resume_half) else $error("resume preset missing");

	sequence s_alarm_hit;
		clk_en && alarm_set;
	endsequence
	property p_alarm_flag;
		@(posedge ref_clk) disable iff (srst)
		s_alarm_hit |=> ctl2_reg.alarm_flag;
	endproperty
	a_alarm_flag: assert property (p_alarm_flag) else $error("alarm flag not set");

	property p_timer_flag;
		@(posedge ref_clk) disable iff (srst)
		clk_en && timer_set |=> ctl2_reg.timer_flag;
	endproperty
	a_timer_flag: assert property (p_timer_flag) else $error("timer flag not set");

	property p_irq_pin;
		@(posedge ref_clk) disable iff (srst)
		!irq_n_oe_n == ((ctl2_reg.alarm_flag && ctl2_reg.alarm_irq_enable)
			|| (ctl2_reg.timer_flag && ctl2_reg.timer_irq_enable));
	endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin disagrees with flags");

	sequence s_sec_wrap;
		clk_en && sec_tick && sec_reg == MAX_MIN_SEC && !wr_sec && !wr_min;
	endsequence
	property p_sec_wrap;
		@(posedge ref_clk) disable iff (srst)
		s_sec_wrap |=> sec_reg == RST_ZERO && min_reg == bcd_step($past(min_reg), MAX_MIN_SEC, RST_ZERO);
	endproperty
	a_sec_wrap: assert property (p_sec_wrap) else $error("seconds wrap or carry wrong");

	property p_hour_wrap;
		@(posedge ref_clk) disable iff (srst)
		clk_en && c_hour && hour_reg == MAX_HOUR && !wr_hour |=> hour_reg == RST_ZERO;
	endproperty
	a_hour_wrap: assert property (p_hour_wrap) else $error("hours did not wrap");

	property p_vl_clear;
		@(posedge ref_clk) disable iff (srst)
		clk_en && wr_sec && !lv_s2_reg |=> !low_voltage_flag_reg;
	endproperty
	a_vl_clear: assert property (p_vl_clear) else $error("low-voltage flag not cleared");

	property p_vl_set;
		@(posedge ref_clk) disable iff (srst)
		clk_en && lv_s2_reg |=> low_voltage_flag_reg;
	endproperty
	a_vl_set: assert property (p_vl_set) else $error("low-voltage flag not set");

	property p_feb_wrap;
		@(posedge ref_clk) disable iff (srst)
		clk_en && c_day && mon_reg == MONTH_FEB && day_reg == DAYS_FEB && year_reg[1:0] == 2'b01 && !wr_day
			|=> day_reg == RST_ONE;
	endproperty
	a_feb_wrap: assert property (p_feb_wrap) else $error("february of a common year overran");
endmodule

`default_nettype wire

// File: verilog/rtc_pkg.sv
// Constants and carrier types for the real-time clock core
package rtc_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] OFF_CONTROL_ONE = 4'h0;
	localparam logic [3:0] OFF_CONTROL_TWO = 4'h1;
	localparam logic [3:0] OFF_SECONDS = 4'h2;
	localparam logic [3:0] OFF_MINUTES = 4'h3;
	localparam logic [3:0] OFF_HOURS = 4'h4;
	localparam logic [3:0] OFF_DAY_OF_MONTH = 4'h5;
	localparam logic [3:0] OFF_MONTH = 4'h7;
	localparam logic [3:0] OFF_YEAR = 4'h8;
	// ----------------------------------------------------------------
	// Field positions and masks
	// ----------------------------------------------------------------
	localparam int BIT_TEST_HI = 7;
	localparam int BIT_HALT = 5;
	localparam int BIT_TEST_LO = 3;
	localparam int BIT_LOW_VOLTAGE = 7;
	localparam logic [7:0] MASK_SECONDS = 8'h7F;
	localparam logic [7:0] MASK_MINUTES = 8'h7F;
	localparam logic [7:0] MASK_HOURS = 8'h3F;
	localparam logic [7:0] MASK_DAY = 8'h3F;
	localparam logic [7:0] MASK_MONTH = 8'h1F;
	localparam logic [7:0] MASK_YEAR = 8'hFF;
	// ----------------------------------------------------------------
	// Reset values and counter limits (packed BCD)
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_ONE = 8'h01;
	localparam logic [7:0] MAX_MIN_SEC = 8'h59;
	localparam logic [7:0] MAX_HOUR = 8'h23;
	localparam logic [7:0] MAX_MONTH = 8'h12;
	localparam logic [7:0] MAX_YEAR = 8'h99;
	localparam logic [7:0] DAYS_LONG = 8'h31;
	localparam logic [7:0] DAYS_SHORT = 8'h30;
	localparam logic [7:0] DAYS_FEB = 8'h28;
	localparam logic [7:0] DAYS_FEB_LEAP = 8'h29;
	localparam logic [7:0] MONTH_FEB = 8'h02;
	localparam logic [7:0] MONTH_APR = 8'h04;
	localparam logic [7:0] MONTH_JUN = 8'h06;
	localparam logic [7:0] MONTH_SEP = 8'h09;
	localparam logic [7:0] MONTH_NOV = 8'h11;
	// ----------------------------------------------------------------
	// Timing: crystal rate and the resume delay
	// ----------------------------------------------------------------
	localparam int XTAL_HZ = 32768;
	localparam int RESUME_DELAY_MS = 500;
	localparam int PRESC_W = 15;
	localparam int RESUME_EDGES = XTAL_HZ * RESUME_DELAY_MS / 1000;
	// Preset so the prescaler wraps after RESUME_EDGES crystal edges
	localparam logic [PRESC_W-1:0] PRESC_RESUME = PRESC_W'(XTAL_HZ - RESUME_EDGES);
	localparam logic [PRESC_W-1:0] PRESC_RST = '0;
	localparam int TAP_1024HZ = 4;
	localparam int TAP_32HZ = 9;
	localparam int TAP_1HZ = 14;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RTC_FREQ_32K = 2'b00,
		RTC_FREQ_1024 = 2'b01,
		RTC_FREQ_32 = 2'b10,
		RTC_FREQ_1 = 2'b11
	} rtc_freq_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rtc_bus_req_t;

	typedef struct packed {
		logic timer_repeat_select;
		logic alarm_flag;
		logic timer_flag;
		logic alarm_irq_enable;
		logic timer_irq_enable;
	} rtc_ctl_two_t;

	localparam rtc_ctl_two_t RST_CTL_TWO = '0;
endpackage

// File: dv/rtc_host_model.sv
// Host-side register master model for the clock core
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model
	import rtc_pkg::*;
(
	// Clock
	input wire logic ref_clk,
	// Register port
	output var rtc_bus_req_t bus_req,
	input wire logic [7:0] reg_rdata
);
	initial bus_req = '0;

	// One-cycle write; test bits of control one always go out as zero
	task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: (a == OFF_CONTROL_ONE) ? (d & 8'h77) : d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus_req.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so take them there
	task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus_req.rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// File: dv/rtc_control_time_calendar_tb.sv
// Self-checking bench for the clock core with host model and crystal source
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module rtc_control_time_calendar_tb
	import rtc_pkg::*;
;
	typedef struct packed {
		logic [3:0] a;
		logic [7:0] d;
		logic [7:0] e;
		logic i;
	} rtc_row_t;
	// Write, expected read-back and expected interrupt pin level
	rtc_row_t rows [14] = '{
		'{4'h1, 8'h1F, 8'h1F, 1'b0}, '{4'h1, 8'h0A, 8'h0A, 1'b0}, '{4'h1, 8'h09, 8'h09, 1'b1},
		'{4'h1, 8'h06, 8'h06, 1'b1}, '{4'h1, 8'h05, 8'h05, 1'b0}, '{4'h1, 8'h10, 8'h10, 1'b1},
		'{4'h3, 8'hFF, 8'h7F, 1'b1}, '{4'h4, 8'hFF, 8'h3F, 1'b1}, '{4'h5, 8'hFF, 8'h3F, 1'b1},
		'{4'h7, 8'hFF, 8'h1F, 1'b1}, '{4'h8, 8'h99, 8'h99, 1'b1}, '{4'h0, 8'h88, 8'h00, 1'b1},
		'{4'h6, 8'h55, 8'h00, 1'b1}, '{4'h2, 8'h59, 8'h59, 1'b1}};
	// Time regs, reset values, last second of Feb 28 in a leap year, and one tick later
	logic [3:0] ta [6] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8};
	logic [7:0] tr [6] = '{8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01};
	logic [7:0] tw [6] = '{8'h59, 8'h59, 8'h23, 8'h28, 8'h02, 8'h04};
	logic [7:0] tx [6] = '{8'h00, 8'h00, 8'h00, 8'h29, 8'h02, 8'h04};
	logic ref_clk, srst, ce, xtal_clk, lv_in, co_en, alarm_ev, timer_ev;
	logic [1:0] co_sel;
	rtc_bus_req_t req;
	logic [7:0] rdata, d;
	logic halted, to_en, rep_sel, tick, co_o, co_oe_n, irq_o, irq_oe_n;
	int n, hi, lo, total_checks = 0, n_mismatch = 0;
	// Open-drain pins with pull-ups
	wire logic co_pin = co_oe_n ? 1'b1 : co_o;
	wire logic irq_pin = irq_oe_n ? 1'b1 : irq_o;

	rtc_core u_dut (.ref_clk(ref_clk), .srst(srst), .clk_en(ce), .bus_req(req), .reg_rdata(rdata),
		.xtal_clk(xtal_clk), .low_voltage_threshold(lv_in), .clock_output_enable(co_en),
		.clock_output_select(co_sel), .alarm_event(alarm_ev), .timer_event(timer_ev),
		.counters_halted(halted), .bus_timeout_enable(to_en), .timer_repeat_select(rep_sel),
		.one_hz_tick(tick), .clock_output_pin_o(co_o), .clock_output_pin_oe_n(co_oe_n),
		.irq_n_o(irq_o), .irq_n_oe_n(irq_oe_n));
	rtc_host_model u_host (.ref_clk(ref_clk), .bus_req(req), .reg_rdata(rdata));

	// Core clock and a free-running crystal, off phase from it
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		xtal_clk = 1'b0;
		#3;
		forever #80 xtal_clk = ~xtal_clk;
	end

	// One-cycle event from the neighbouring alarm or timer logic
	task automatic pulse(input logic is_alarm);
		@(posedge ref_clk);
		alarm_ev <= is_alarm;
		timer_ev <= !is_alarm;
		@(posedge ref_clk);
		alarm_ev <= 1'b0;
		timer_ev <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		srst = 1'b1;
		ce = 1'b1;
		lv_in = 1'b0;
		co_en = 1'b0;
		co_sel = 2'b00;
		alarm_ev = 1'b0;
		timer_ev = 1'b0;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		foreach (rows[i]) begin
			u_host.write_reg(rows[i].a, rows[i].d);
			u_host.read_reg(rows[i].a, d);
			`CHK("readback", rows[i].e, d)
			`CHK("irq pin", rows[i].i, irq_pin)
			if (rows[i].a == OFF_CONTROL_TWO) `CHK("repeat select", rows[i].d[4], rep_sel)
		end
		$display("register table test done");
		// Mid-run reset brings back the start state, flag included
		@(posedge ref_clk);
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		foreach (ta[i]) begin
			u_host.read_reg(ta[i], d);
			`CHK("reset value", tr[i], d)
		end
		`CHK("irq pin after reset", 1'b1, irq_pin)
		// Flag was read above before this clearing write
		u_host.write_reg(OFF_SECONDS, 8'h00);
		u_host.read_reg(OFF_SECONDS, d);
		`CHK("flag cleared", 8'h00, d)
		@(posedge ref_clk);
		lv_in <= 1'b1;
		repeat (5) @(posedge ref_clk);
		lv_in <= 1'b0;
		u_host.read_reg(OFF_SECONDS, d);
		`CHK("flag set by dip", 8'h80, d)
		$display("reset and supply test done");
		// Each event with its own enable off, then on
		for (int k = 0; k < 4; k++) begin
			u_host.write_reg(OFF_CONTROL_TWO, {6'h00, k[1] ~^ k[0], k[1] ^ k[0]});
			pulse(k[1]);
			`CHK("event irq pin", !k[0], irq_pin)
			u_host.read_reg(OFF_CONTROL_TWO, d);
			`CHK("event flags", {4'h0, k[1], !k[1], k[1] ~^ k[0], k[1] ^ k[0]}, d)
		end
		// A frozen core must not take an event while the enable is low
		u_host.write_reg(OFF_CONTROL_TWO, 8'h00);
		@(posedge ref_clk);
		ce <= 1'b0;
		pulse(1'b1);
		@(posedge ref_clk);
		ce <= 1'b1;
		u_host.read_reg(OFF_CONTROL_TWO, d);
		`CHK("event while frozen", 8'h00, d)
		$display("event test done");
		@(posedge ref_clk);
		co_en <= 1'b1;
		u_host.write_reg(OFF_CONTROL_TWO, 8'h03);
		u_host.write_reg(OFF_CONTROL_ONE, 8'h20);
		#1;
		`CHK("halted", 1'b1, halted)
		`CHK("bus timeout enable", 1'b0, to_en)
		pulse(1'b1);
		pulse(1'b0);
		u_host.read_reg(OFF_CONTROL_TWO, d);
		`CHK("events while halted", 8'h03, d)
		// Only the crystal-rate selection keeps running while halted
		for (int s = 0; s < 4; s++) begin
			co_sel <= s[1:0];
			repeat (10) @(posedge ref_clk);
			hi = 0;
			lo = 0;
			repeat (40) begin
				@(posedge ref_clk);
				#1;
				if (co_pin) hi++;
				else lo++;
			end
			`CHK("halted output toggles", s == 0, hi > 0 && lo > 0)
			if (s != 0) `CHK("halted output high count", 0, hi)
		end
		// Host halts before setting time, as recommended
		foreach (ta[i]) u_host.write_reg(ta[i], tw[i]);
		u_host.write_reg(OFF_CONTROL_ONE, 8'h00);
		for (n = 0; n < 140000 && tick !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		if (n >= 140000) begin
			n_mismatch++;
			$display("[ERR] one_hz_tick expected 1 seen 0");
		end else begin
			`CHK("resume delay in range", 1'b1, n > 131050 && n < 131100)
			foreach (ta[i]) begin
				u_host.read_reg(ta[i], d);
				`CHK("time after rollover", tx[i], d)
			end
		end
		$display("halt and resume test done");
		complete_run();
	end
endmodule
`default_nettype wire
